// ### pkg/abx_pkg.sv
package abx_pkg;
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADR_W = 5;
  localparam int unsigned BIDX_W = 3;

  // Opcode fields and values
  localparam logic [5:0] OP_AND_W_FILE  = 6'h05;
  localparam logic [3:0] OP_AND_LIT     = 4'he;
  localparam logic [3:0] OP_BIT_CLR     = 4'h4;
  localparam int unsigned DEST_BIT      = 5;
  localparam int unsigned BIDX_LSB      = 5;

  // File addresses of special registers
  localparam logic [4:0] ADR_TIMER_ZERO = 5'h01;
  localparam logic [4:0] ADR_PORT_LO    = 5'h05;
  localparam logic [4:0] ADR_PORT_HI    = 5'h07;

  typedef enum logic [1:0] {
    ABX_NONE = 2'b00,
    ABX_ANDF = 2'b01,
    ABX_ANDL = 2'b11,
    ABX_BCLR = 2'b10
  } abx_op_t;
endpackage

// ### pkg/abx_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface abx_dec_if;
  import abx_pkg::*;
  logic    [11:0] insn;
  abx_op_t        op;
  logic    [4:0]  fadr;
  logic    [2:0]  bidx;
  logic    [7:0]  lit;
  logic           dest_f;
  logic           is_port;
  logic           is_tmr;
  modport dec (input insn, output op, fadr, bidx, lit, dest_f, is_port, is_tmr);
  modport exe (output insn, input op, fadr, bidx, lit, dest_f, is_port, is_tmr);
endinterface
`default_nettype wire

// ### rtl/abx_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module abx_decoder (
  abx_dec_if.dec d
);
  import abx_pkg::*;
  wire hit_andf = (d.insn[11:6] == OP_AND_W_FILE); // see (RULE1)
  wire hit_andl = (d.insn[11:8] == OP_AND_LIT);    // see (RULE3)
  wire hit_bclr = (d.insn[11:8] == OP_BIT_CLR);    // see (RULE5)

  assign d.op      = hit_andf ? ABX_ANDF : hit_andl ? ABX_ANDL : hit_bclr ? ABX_BCLR : ABX_NONE;
  assign d.fadr    = d.insn[4:0];
  assign d.bidx    = d.insn[7:5];
  assign d.lit     = d.insn[7:0];
  assign d.dest_f  = d.insn[DEST_BIT];
  assign d.is_port = (d.insn[4:0] >= ADR_PORT_LO) && (d.insn[4:0] <= ADR_PORT_HI);
  assign d.is_tmr  = (d.insn[4:0] == ADR_TIMER_ZERO);
endmodule
`default_nettype wire

// ### rtl/abx_exec.sv
// Operation
// (RULE1) AND-with-file opcode 000101, d, 5-bit f
// (RULE2) AND W with f; d picks destination
// (RULE3) AND-with-literal opcode 1110, 8-bit literal
// (RULE4) AND literal into W, update zero
// (RULE5) Bit-clear opcode 0100, bit index, f
// (RULE6) Clear chosen bit, flags untouched
// (RULE7) Port operands come from pin levels
// (RULE8) Timer write clears assigned prescaler
// (RULE9) One cycle, one word each
`timescale 1ns/1ps
`default_nettype none
module abx_exec #(
  parameter int unsigned DW = abx_pkg::DATA_W,
  parameter int unsigned AW = abx_pkg::FADR_W
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       insn_vld,
  input  wire logic [abx_pkg::INSN_W-1:0] insn,
  input  wire logic [DW-1:0]              w_in,
  input  wire logic [DW-1:0]              file_rd,
  input  wire logic [DW-1:0]              pin_rd,
  input  wire logic                       psa_tmr,
  output logic                            w_we,
  output logic      [DW-1:0]              w_wd,
  output logic                            file_we,
  output logic      [AW-1:0]              file_adr,
  output logic      [DW-1:0]              file_wd,
  output logic                            z_we,
  output logic                            z_val,
  output logic                            psc_clr,
  output logic                            done
);
  import abx_pkg::*;

  // Decode slices and the 8-bit masks follow the fixed instruction format
  if (DW != DATA_W || AW != FADR_W) begin : g_width_check
    $error("abx_exec serves only the fixed data and address widths");
  end

  // Release is resynchronised so every output flop leaves reset on the same edge
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  abx_dec_if dif ();
  assign dif.insn = insn;
  abx_decoder u_dec (
    .d (dif)
  );

  // Ports read back the pins so input-driven bits are not overwritten by stale latch data
  wire [7:0] opnd_f   = dif.is_port ? pin_rd : file_rd;                 // see (RULE7)
  wire       do_andf  = insn_vld && (dif.op == ABX_ANDF);
  wire       do_andl  = insn_vld && (dif.op == ABX_ANDL);
  wire       do_bclr  = insn_vld && (dif.op == ABX_BCLR);
  wire [7:0] and_f    = w_in & opnd_f;                                  // see (RULE2)
  wire [7:0] and_l    = w_in & dif.lit;                                 // see (RULE4)
  wire [7:0] clr_mask = ~(8'h01 << dif.bidx);
  wire [7:0] bclr_v   = opnd_f & clr_mask;                              // see (RULE6)
  wire       f_wr     = (do_andf && dif.dest_f) || do_bclr;
  wire       w_wr     = (do_andf && !dif.dest_f) || do_andl;
  wire [7:0] res      = do_andl ? and_l : do_andf ? and_f : bclr_v;

  logic       w_we_d;
  logic       file_we_d;
  logic       z_we_d;
  logic       z_val_d;
  logic       psc_clr_d;
  logic       done_d;
  logic [7:0] w_wd_d;
  logic [7:0] file_wd_d;
  assign w_we_d    = w_wr;                                              // see (RULE2)
  assign w_wd_d    = res;
  assign file_we_d = f_wr;
  assign file_wd_d = res;
  assign z_we_d    = do_andf || do_andl;                                // see (RULE6)
  assign z_val_d   = (res == 8'h00);                                    // see (RULE4)
  assign psc_clr_d = f_wr && dif.is_tmr && psa_tmr;                     // see (RULE8)
  assign done_d    = do_andf || do_andl || do_bclr;                     // see (RULE9)

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      w_we     <= 1'b0;
      w_wd     <= 8'h00;
      file_we  <= 1'b0;
      file_adr <= 5'h00;
      file_wd  <= 8'h00;
      z_we     <= 1'b0;
      z_val    <= 1'b0;
      psc_clr  <= 1'b0;
      done     <= 1'b0;
    end else begin
      w_we     <= w_we_d;
      w_wd     <= w_wd_d;
      file_we  <= file_we_d;
      file_adr <= dif.fadr;
      file_wd  <= file_wd_d;
      z_we     <= z_we_d;
      z_val    <= z_val_d;
      psc_clr  <= psc_clr_d;
      done     <= done_d;
    end
  end

  // Opcode matches for the checks, worked out apart from the decoder on purpose
  wire chk_andf = insn_vld && (insn[11:6] == 6'h05);
  wire chk_andl = insn_vld && (insn[11:8] == 4'he);
  wire chk_bclr = insn_vld && (insn[11:8] == 4'h4);
  wire chk_tmr  = (insn[4:0] == 5'h01);
  wire chk_port = (insn[4:0] >= 5'h05) && (insn[4:0] <= 5'h07);
  wire chk_none = !(chk_andf || chk_andl || chk_bclr);
  wire any_out  = w_we || file_we || z_we || psc_clr || done;

  // Recognition, destination and result
  a_andf_file: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE1)
    chk_andf
    |=> (file_adr == $past(insn[4:0]) && z_we && done))
    else $error("and-with-file address or zero wrong");

  a_andf_dest: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE2)
    chk_andf
    |=> (w_we == !$past(insn[5]) && file_we == $past(insn[5])))
    else $error("and-with-file destination wrong");

  a_andf_value: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE2)
    (chk_andf && !chk_port)
    |=> (($past(insn[5]) ? file_wd : w_wd) == ($past(w_in) & $past(file_rd))))
    else $error("and-with-file result wrong");

  a_andf_zero: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE2)
    chk_andf
    |=> (z_val == (($past(insn[5]) ? file_wd : w_wd) == 8'h00)))
    else $error("and-with-file zero flag wrong");

  a_andl_result: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE4)
    chk_andl
    |=> (w_we && w_wd == ($past(w_in) & $past(insn[7:0]))
      && z_we && z_val == (w_wd == 8'h00)))
    else $error("and-with-literal result wrong");

  a_andl_no_file: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE3)
    chk_andl
    |=> (!file_we && !psc_clr && done))
    else $error("and-with-literal touched a file register");

  a_bclr_addr: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE5)
    chk_bclr
    |=> (file_adr == $past(insn[4:0]) && done))
    else $error("bit-clear address wrong");

  a_bclr_bit: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE6)
    chk_bclr
    |=> (file_we && !z_we && !w_we && file_wd[$past(insn[7:5])] == 1'b0))
    else $error("bit-clear wrong");

  a_bclr_keep: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE6)
    (chk_bclr && !chk_port)
    |=> ((file_wd | (8'h01 << $past(insn[7:5])))
      == ($past(file_rd) | (8'h01 << $past(insn[7:5])))))
    else $error("bit-clear disturbed other bits");

  // Port operands
  a_port_pins: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE7)
    (chk_andf && chk_port)
    |=> (file_wd == ($past(w_in) & $past(pin_rd))))
    else $error("port operand not from pins");

  a_bclr_pins: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE7)
    (chk_bclr && chk_port)
    |=> (file_wd == ($past(pin_rd) & ~(8'h01 << $past(insn[7:5])))))
    else $error("bit-clear port operand not from pins");

  // Prescaler
  a_psc_clear: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE8)
    psc_clr
    |-> ($past(insn[4:0]) == 5'h01 && file_we && $past(psa_tmr)))
    else $error("prescaler clear without timer write");

  a_psc_needed: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE8)
    (((chk_andf && insn[5]) || chk_bclr) && chk_tmr && psa_tmr)
    |=> psc_clr)
    else $error("timer write left prescaler running");

  a_psc_w_dest: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE8)
    (chk_andf && !insn[5])
    |=> !psc_clr)
    else $error("prescaler cleared without a file write");

  // Timing and refusal
  a_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE9)
    (chk_andf || chk_andl || chk_bclr)
    |=> done)
    else $error("instruction not single cycle");

  a_done_write: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE9)
    done
    |-> (w_we || file_we))
    else $error("done without a write");

  a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE9)
    !insn_vld
    |=> !any_out)
    else $error("output pulse without a valid instruction");

  a_other_refused: assert property (@(posedge mclk) disable iff (!rst_n) // see (RULE1)
    (insn_vld && chk_none)
    |=> !any_out)
    else $error("foreign opcode executed");

  // Main scenarios
  c_andf_file: cover property (@(posedge mclk) do_andf && dif.dest_f);
  c_andl:      cover property (@(posedge mclk) do_andl && (and_l == 8'h00));
  c_bclr_tmr:  cover property (@(posedge mclk) do_bclr && dif.is_tmr && psa_tmr);
  c_andf_port: cover property (@(posedge mclk) do_andf && dif.is_port);
  c_bclr_port: cover property (@(posedge mclk) do_bclr && dif.is_port);
endmodule
`default_nettype wire

// ### test/test_and_and_bit_clear_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_and_and_bit_clear_exec;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        insn_vld = 1'b0;
  logic [11:0] insn = 12'h000;
  logic [7:0]  w_in = 8'h00;
  logic [7:0]  file_rd = 8'h00;
  logic [7:0]  pin_rd = 8'h00;
  logic        psa_tmr = 1'b0;
  logic        w_we, file_we, z_we, z_val, psc_clr, done;
  logic [7:0]  w_wd, file_wd;
  logic [4:0]  file_adr;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  abx_exec u_abx_exec (.mclk, .rst_b, .insn_vld, .insn, .w_in, .file_rd, .pin_rd, .psa_tmr,
    .w_we, .w_wd, .file_we, .file_adr, .file_wd, .z_we, .z_val, .psc_clr, .done);

  always #12.5 mclk = ~mclk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Inputs change at the falling edge; the result is looked at one falling edge later
  task automatic go(input logic [11:0] i, input logic [7:0] w, f, p, input logic ps, v);
    insn = i;
    w_in = w;
    file_rd = f;
    pin_rd = p;
    psa_tmr = ps;
    insn_vld = v;
    @(negedge mclk);
  endtask

  // Flag order: w_we, file_we, z_we, z_val, psc_clr, done; data only checked when enabled
  task automatic ck(input logic [7:0] ewd, efd, input logic [5:0] fl);
    chk("w_we", 8'(fl[5]), 8'(w_we));
    if (fl[5]) chk("w_wd", ewd, w_wd);
    chk("file_we", 8'(fl[4]), 8'(file_we));
    if (fl[4]) chk("file_adr", 8'(insn[4:0]), 8'(file_adr));
    if (fl[4]) chk("file_wd", efd, file_wd);
    chk("z_we", 8'(fl[3]), 8'(z_we));
    if (fl[3]) chk("z_val", 8'(fl[2]), 8'(z_val));
    chk("psc_clr", 8'(fl[1]), 8'(psc_clr));
    chk("done", 8'(fl[0]), 8'(done));
  endtask

  task automatic t_andf;
    go(12'h14a, 8'ha3, 8'h5f, 8'h00, 1'b0, 1'b1);
    ck(8'h03, 8'h00, 6'h29);
    go(12'h17f, 8'h17, 8'hc2, 8'h00, 1'b0, 1'b1);
    ck(8'h00, 8'h02, 6'h19);
    go(12'h140, 8'hf0, 8'h0f, 8'h00, 1'b0, 1'b1);
    ck(8'h00, 8'h00, 6'h2d);
    $display("test and_file finished");
  endtask

  task automatic t_andl;
    go(12'he5f, 8'ha3, 8'hff, 8'h00, 1'b0, 1'b1);
    ck(8'h03, 8'h00, 6'h29);
    go(12'he00, 8'hff, 8'hff, 8'h00, 1'b0, 1'b1);
    ck(8'h00, 8'h00, 6'h2d);
    $display("test and_literal finished");
  endtask

  task automatic t_bclr;
    for (int b = 0; b < 8; b++) begin
      go({4'h4, 3'(b), 5'h1f}, 8'h00, 8'hff, 8'h00, 1'b0, 1'b1);
      ck(8'h00, 8'hff & ~(8'h01 << b), 6'h11);
    end
    $display("test bit_clear finished");
  endtask

  // Pins disagree with the latch so the wrong operand source shows
  task automatic t_port;
    go(12'h165, 8'h3c, 8'hff, 8'h0f, 1'b0, 1'b1);
    ck(8'h00, 8'h0c, 6'h19);
    go(12'h406, 8'h00, 8'h00, 8'h81, 1'b0, 1'b1);
    ck(8'h00, 8'h80, 6'h11);
    $display("test port_operand finished");
  endtask

  task automatic t_tmr;
    go(12'h161, 8'hff, 8'h55, 8'h00, 1'b1, 1'b1);
    ck(8'h00, 8'h55, 6'h1b);
    go(12'h141, 8'hff, 8'h55, 8'h00, 1'b1, 1'b1);
    ck(8'h55, 8'h00, 6'h29);
    go(12'h4e1, 8'h00, 8'hff, 8'h00, 1'b1, 1'b1);
    ck(8'h00, 8'h7f, 6'h13);
    go(12'h4e1, 8'h00, 8'hff, 8'h00, 1'b0, 1'b1);
    ck(8'h00, 8'h7f, 6'h11);
    $display("test timer_prescaler finished");
  endtask

  task automatic t_refuse;
    go(12'he5f, 8'hff, 8'hff, 8'h00, 1'b0, 1'b0);
    ck(8'h00, 8'h00, 6'h00);
    go(12'h1c0, 8'hff, 8'hff, 8'h00, 1'b0, 1'b1);
    ck(8'h00, 8'h00, 6'h00);
    go(12'h5e5, 8'hff, 8'hff, 8'h00, 1'b0, 1'b1);
    ck(8'h00, 8'h00, 6'h00);
    $display("test refused finished");
  endtask

  // Reset in mid-run clears the outputs at once; nothing is offered until it is through
  task automatic t_reset;
    go(12'he5f, 8'ha3, 8'hff, 8'h00, 1'b0, 1'b1);
    rst_b = 1'b0;
    insn_vld = 1'b0;
    #1;
    ck(8'h00, 8'h00, 6'h00);
    @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    ck(8'h00, 8'h00, 6'h00);
    go(12'he5f, 8'ha3, 8'hff, 8'h00, 1'b0, 1'b1);
    ck(8'h03, 8'h00, 6'h29);
    $display("test mid_reset finished");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // The tests need under a hundred cycles; the ceiling only catches a hang
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 400) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(negedge mclk);
    ck(8'h00, 8'h00, 6'h00);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    t_andf();
    t_andl();
    t_bclr();
    t_port();
    t_tmr();
    t_refuse();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
